/* rtl/toi_pkg.sv */
// shared constants and carrier types of the transmit overhead insert port
package toi_pkg;

  // counter widths inside the port
  localparam int unsigned CNT_W = 8;
  localparam int unsigned HDLC_CNT_W = 3;

  // default overhead slot spacing in bit clocks and slots per frame
  localparam int unsigned OH_SPACING_DEF = 8;
  localparam int unsigned OH_PER_FRAME_DEF = 8;

  // hdlc demand clock is one eighth of the bit clock
  localparam logic [HDLC_CNT_W-1:0] HDLC_DIV_LAST = 3'h7;
  localparam logic [HDLC_CNT_W-1:0] HDLC_HALF_LAST = 3'h3;

  // bit positions of the two shared pins inside the hdlc byte
  localparam int unsigned HDLC_B5_POS = 5;
  localparam int unsigned HDLC_B4_POS = 4;

  // synchroniser depth and reset value
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic SYNC_RST = 1'b0;

  // pins arriving from outside the clock domain
  typedef struct packed {
    logic       bit_clk;
    logic       hdlc_mode;
    logic       ser_in;
    logic       insert_en;
    logic [1:0] hdlc_hi;
    logic [3:0] hdlc_lo;
  } toi_pins_t;

  localparam int unsigned PINS_W = $bits(toi_pins_t);

  // overhead bit handed to the framing engine
  typedef struct packed {
    logic             valid;
    logic             data;
    logic [CNT_W-1:0] idx;
  } toi_ovh_t;

  // byte handed to the hdlc controller
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } toi_hdlc_t;

  // complete state of the port
  typedef struct packed {
    logic                  clk_q;
    logic [CNT_W-1:0]      bit_cnt;
    logic [CNT_W-1:0]      slot;
    logic [HDLC_CNT_W-1:0] hdlc_cnt;
    logic                  ovh_clk;
    logic                  mark;
    logic                  hdlc_clk;
    toi_ovh_t              ovh;
    toi_hdlc_t             hdlc;
  } toi_state_t;

  localparam toi_state_t STATE_RST = '0;

endpackage

/* rtl/toi_sync.sv */
// three stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
`default_nettype none

module toi_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         CLK,
  input  wire logic         SYS_RST,
  input  wire logic [W-1:0] PIN,
  output var  logic [W-1:0] STABLE
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } toi_sync_t;

  toi_sync_t sync_ff;
  toi_sync_t nxt_sync;

  // width must be at least one bit
  initial begin
    if (W < 1) $error("toi_sync width must be positive");
  end

  // shift chain; a change counts once stages two and three agree
  always_comb begin
    nxt_sync = sync_ff;
    nxt_sync.s1 = PIN;
    nxt_sync.s2 = sync_ff.s1;
    nxt_sync.s3 = sync_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (sync_ff.s2[i] == sync_ff.s3[i]) begin
        nxt_sync.stable[i] = sync_ff.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sync_ff <= {4{{W{toi_pkg::SYNC_RST}}}};
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign STABLE = sync_ff.stable;

endmodule

`default_nettype wire

/* rtl/toi_port.sv */
// transmit overhead insert port with shared hdlc byte input
`timescale 1ns/100ps
`default_nettype none

module toi_port #(
  parameter int unsigned OH_SPACING   = toi_pkg::OH_SPACING_DEF,
  parameter int unsigned OH_PER_FRAME = toi_pkg::OH_PER_FRAME_DEF
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              TX_BIT_CLK,
  input  wire logic              HDLC_MODE,
  input  wire logic              OVH_SER_IN,
  input  wire logic              OVH_INSERT_EN,
  input  wire logic [1:0]        HDLC_BYTE_IN_HI,
  input  wire logic [3:0]        HDLC_BYTE_IN_LO,
  output var  logic              OVH_CLK_OUT,
  output var  logic              OVH_FRAME_MARK,
  output var  logic              HDLC_DEMAND_CLK,
  output var  toi_pkg::toi_ovh_t OVH_BIT,
  output var  toi_pkg::toi_hdlc_t HDLC_BYTE
);

  localparam logic [toi_pkg::CNT_W-1:0] SPACE_LAST =
    toi_pkg::CNT_W'(OH_SPACING - 1);
  localparam logic [toi_pkg::CNT_W-1:0] FALL_AT =
    toi_pkg::CNT_W'(OH_SPACING / 2 - 1);
  localparam logic [toi_pkg::CNT_W-1:0] SLOT_LAST =
    toi_pkg::CNT_W'(OH_PER_FRAME - 1);
  localparam logic [toi_pkg::CNT_W-1:0] CNT_ONE = 8'h01;

  toi_pkg::toi_state_t st_ff;
  toi_pkg::toi_state_t nxt_st;
  toi_pkg::toi_pins_t  pins_raw;
  toi_pkg::toi_pins_t  pins;
  logic                bit_rise;

  // spacing must be even and fit the counters
  initial begin
    if (OH_SPACING < 2 || OH_SPACING > 254 || (OH_SPACING % 2) != 0) begin
      $error("OH_SPACING must be even and within 2..254");
    end
    if (OH_PER_FRAME < 1 || OH_PER_FRAME > 256) begin
      $error("OH_PER_FRAME must be within 1..256");
    end
  end

  // all pins come from outside the clock domain
  always_comb begin
    pins_raw.bit_clk   = TX_BIT_CLK;
    pins_raw.hdlc_mode = HDLC_MODE;
    pins_raw.ser_in    = OVH_SER_IN;
    pins_raw.insert_en = OVH_INSERT_EN;
    pins_raw.hdlc_hi   = HDLC_BYTE_IN_HI;
    pins_raw.hdlc_lo   = HDLC_BYTE_IN_LO;
  end

  toi_sync #(
    .W (toi_pkg::PINS_W)
  ) u_sync (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .PIN     (pins_raw),
    .STABLE  (pins)
  );

  // rising edge of the sampled bit clock
  assign bit_rise = pins.bit_clk & ~st_ff.clk_q;

  // next state: overhead clock, frame marker, sampling and hdlc demand clock
  always_comb begin
    nxt_st = st_ff;
    nxt_st.clk_q = pins.bit_clk;
    nxt_st.ovh.valid = 1'b0;
    nxt_st.hdlc.valid = 1'b0;
    if (bit_rise) begin
      if (pins.hdlc_mode) begin
        // overhead port parked while hdlc mode holds
        nxt_st.ovh_clk = 1'b0;
        nxt_st.mark = 1'b0;
        nxt_st.bit_cnt = '0;
        nxt_st.slot = '0;
        if (st_ff.hdlc_cnt == toi_pkg::HDLC_DIV_LAST) begin
          nxt_st.hdlc_cnt = '0;
          nxt_st.hdlc_clk = 1'b1;
          nxt_st.hdlc.valid = 1'b1;
          nxt_st.hdlc.data = {pins.hdlc_hi, pins.ser_in, pins.insert_en,
                              pins.hdlc_lo};
        end else begin
          nxt_st.hdlc_cnt = st_ff.hdlc_cnt + 3'h1;
          if (st_ff.hdlc_cnt == toi_pkg::HDLC_HALF_LAST) begin
            nxt_st.hdlc_clk = 1'b0;
          end
        end
      end else begin
        nxt_st.hdlc_clk = 1'b0;
        nxt_st.hdlc_cnt = toi_pkg::HDLC_DIV_LAST;
        if (st_ff.bit_cnt == SPACE_LAST) begin
          // start of an overhead clock period
          nxt_st.bit_cnt = '0;
          nxt_st.ovh_clk = 1'b1;
          nxt_st.mark = (st_ff.slot == '0);
        end else begin
          nxt_st.bit_cnt = st_ff.bit_cnt + CNT_ONE;
          if ((st_ff.bit_cnt == FALL_AT) && st_ff.ovh_clk) begin
            // no fall, no sample while the clock has not risen yet after reset or hdlc
            // falling edge: sample only when insert is enabled
            nxt_st.ovh_clk = 1'b0;
            if (pins.insert_en) begin
              nxt_st.ovh.valid = 1'b1;
              nxt_st.ovh.data = pins.ser_in;
              nxt_st.ovh.idx = st_ff.slot;
            end
            nxt_st.slot = (st_ff.slot == SLOT_LAST) ? '0 : st_ff.slot + CNT_ONE;
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_ff <= toi_pkg::STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign OVH_CLK_OUT     = st_ff.ovh_clk;
  assign OVH_FRAME_MARK  = st_ff.mark;
  assign HDLC_DEMAND_CLK = st_ff.hdlc_clk;
  assign OVH_BIT         = st_ff.ovh;
  assign HDLC_BYTE       = st_ff.hdlc;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // serial data reaches the overhead bit output unchanged
  chk_ovh_data_path: assert property (
    st_ff.ovh.valid |-> st_ff.ovh.data == $past(pins.ser_in))
    else $error("overhead bit differs from serial input");

  // every enabled falling edge takes a bit
  chk_fall_sample_en: assert property (
    $fell(st_ff.ovh_clk) && $past(pins.insert_en) && !$past(pins.hdlc_mode)
    |-> st_ff.ovh.valid)
    else $error("enabled falling edge did not sample");

  // bits are taken only on a falling edge
  chk_sample_on_fall: assert property (
    st_ff.ovh.valid |-> $fell(st_ff.ovh_clk))
    else $error("overhead bit taken off a falling edge");

  // disabled port takes nothing
  chk_ignore_disabled: assert property (
    !$past(pins.insert_en) |-> !st_ff.ovh.valid)
    else $error("bit taken while insert disabled");

  // hdlc byte bit five comes from the serial pin
  chk_hdlc_bit_five: assert property (
    st_ff.hdlc.valid |-> st_ff.hdlc.data[toi_pkg::HDLC_B5_POS] == $past(pins.ser_in))
    else $error("hdlc bit 5 not from serial pin");

  // hdlc byte bit four comes from the insert pin
  chk_hdlc_bit_four: assert property (
    st_ff.hdlc.valid |-> st_ff.hdlc.data[toi_pkg::HDLC_B4_POS] == $past(pins.insert_en))
    else $error("hdlc bit 4 not from insert pin");

  // overhead clock rises only on a bit clock rise, then stays high a while
  chk_ovh_clk_shape: assert property (
    $rose(st_ff.ovh_clk) |-> $past(bit_rise) ##1 st_ff.ovh_clk [*3])
    else $error("overhead clock edge off the bit clock");

  // hdlc mode keeps the overhead port quiet
  chk_hdlc_port_off: assert property (
    $past(pins.hdlc_mode) && $past(bit_rise) |-> !st_ff.ovh.valid && !st_ff.ovh_clk)
    else $error("overhead port active in hdlc mode");

  // marker rises with the overhead clock and falls only at the next rise or when hdlc mode parks it
  chk_mark_width: assert property (
    ($rose(st_ff.mark) |-> $rose(st_ff.ovh_clk)) and
    ($fell(st_ff.mark) |-> $rose(st_ff.ovh_clk) || $past(pins.hdlc_mode)))
    else $error("frame marker not one overhead clock period");

  // marker only at the first slot of a frame
  chk_mark_first_slot: assert property (
    $rose(st_ff.ovh_clk) && st_ff.mark |-> st_ff.slot == '0)
    else $error("frame marker off the first overhead slot");

  // each real falling edge moves on to the next slot of the frame
  chk_slot_advance: assert property (
    $fell(st_ff.ovh_clk) && !$past(pins.hdlc_mode) |->
      st_ff.slot == (($past(st_ff.slot) == SLOT_LAST) ? '0 : $past(st_ff.slot) + CNT_ONE))
    else $error("overhead slot did not advance on a falling edge");

  // demand clock and hdlc bytes stay idle outside hdlc mode
  chk_hdlc_clk_idle: assert property (
    !$past(pins.hdlc_mode) && $past(bit_rise) |-> !st_ff.hdlc_clk && !st_ff.hdlc.valid)
    else $error("demand clock active outside hdlc mode");

  // marker parked while hdlc mode holds
  chk_mark_parked: assert property (
    $past(pins.hdlc_mode) && $past(bit_rise) |-> !st_ff.mark)
    else $error("frame marker active in hdlc mode");

  // hdlc byte taken exactly at the demand clock rise
  chk_hdlc_rise_take: assert property (
    $rose(st_ff.hdlc_clk) |-> st_ff.hdlc.valid)
    else $error("hdlc byte not taken on demand clock rise");

endmodule

`default_nettype wire

/* tb/toi_term_model.sv */
// terminal equipment model feeding overhead bits and hdlc bytes
`timescale 1ns/100ps
`default_nettype none

module toi_term_model (
  input  wire logic  CLK,
  input  wire logic  OVH_CLK_OUT,
  input  wire logic  HDLC_DEMAND_CLK,
  input  wire logic  HDLC_MODE,
  input  wire logic  EN_REQ,
  output var  logic       OVH_SER_IN,
  output var  logic       OVH_INSERT_EN,
  output var  logic [1:0] HDLC_BYTE_IN_HI,
  output var  logic [3:0] HDLC_BYTE_IN_LO
);
  logic       ovh_q = 1'b0;
  logic       dem_q = 1'b0;
  logic [7:0] byte_q = 8'hA5;
  logic [6:0] pat_q = 7'h5A;

  initial begin
    OVH_SER_IN = 1'b0;
    OVH_INSERT_EN = 1'b0;
    HDLC_BYTE_IN_HI = 2'h0;
    HDLC_BYTE_IN_LO = 4'h0;
  end

  // overhead data changes only after a clock rise, so it is settled at the next fall; hdlc bytes change after a demand clock fall
  always @(negedge CLK) begin
    ovh_q <= OVH_CLK_OUT;
    dem_q <= HDLC_DEMAND_CLK;
    if (HDLC_MODE) begin
      if (dem_q && !HDLC_DEMAND_CLK)
        byte_q <= byte_q + 8'h3B;
      {HDLC_BYTE_IN_HI, OVH_SER_IN, OVH_INSERT_EN, HDLC_BYTE_IN_LO} <= byte_q;
    end else if (!ovh_q && OVH_CLK_OUT) begin
      pat_q <= {pat_q[5:0], pat_q[6] ^ pat_q[5]};
      OVH_SER_IN <= pat_q[0];
      OVH_INSERT_EN <= EN_REQ;
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench of the overhead insert port with terminal model
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic               clk;
  logic               sys_rst;
  logic               bit_clk;
  logic               hdlc_mode;
  logic               en_req;
  logic               ser_in;
  logic               ins_en;
  logic [1:0]         hi;
  logic [3:0]         lo;
  logic               ovh_clk;
  logic               mark;
  logic               dem_clk;
  toi_pkg::toi_ovh_t  ovh_bit;
  toi_pkg::toi_hdlc_t hdlc_byte;
  logic               ovh_q = 1'b0;
  int                 fail_count = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  int                 rises = 0;
  int                 falls = 0;
  int                 valids = 0;
  int                 bytes = 0;
  int                 last_rise = 0;
  int                 last_byte = 0;

  toi_port #(.OH_SPACING(4), .OH_PER_FRAME(3)) toi_port_inst (
    .CLK(clk), .SYS_RST(sys_rst), .TX_BIT_CLK(bit_clk), .HDLC_MODE(hdlc_mode),
    .OVH_SER_IN(ser_in), .OVH_INSERT_EN(ins_en), .HDLC_BYTE_IN_HI(hi),
    .HDLC_BYTE_IN_LO(lo), .OVH_CLK_OUT(ovh_clk), .OVH_FRAME_MARK(mark),
    .HDLC_DEMAND_CLK(dem_clk), .OVH_BIT(ovh_bit), .HDLC_BYTE(hdlc_byte));

  toi_term_model toi_term_model_inst (
    .CLK(clk), .OVH_CLK_OUT(ovh_clk), .HDLC_DEMAND_CLK(dem_clk), .HDLC_MODE(hdlc_mode),
    .EN_REQ(en_req), .OVH_SER_IN(ser_in), .OVH_INSERT_EN(ins_en),
    .HDLC_BYTE_IN_HI(hi), .HDLC_BYTE_IN_LO(lo));

  // system clock and unrelated bit clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    bit_clk = 1'b0;
    #3.1;
    forever #62.5 bit_clk = ~bit_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watches outputs off the sampling edge against what the model drove
  always @(negedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      tally_and_finish();
    end
    if (!sys_rst && !ovh_q && ovh_clk) begin
      check("mark_at_rise", mark, 8'(rises % 3 == 0));
      if (rises > 0)
        check("ovh_period", 8'((cyc - last_rise) inside {[48:52]}), 8'h01);
      last_rise = cyc;
      rises++;
    end
    if (!sys_rst && (ovh_bit.valid || (ovh_q && !ovh_clk))) begin
      check("ovh_valid", 8'(ovh_bit.valid), 8'(ovh_q && !ovh_clk && ins_en));
      check("mark_at_fall", mark, 8'((rises - 1) % 3 == 0));
      if (ovh_bit.valid) begin
        check("ovh_data", 8'(ovh_bit.data), 8'(ser_in));
        check("ovh_slot", ovh_bit.idx, 8'((rises - 1) % 3));
        valids++;
      end
    end
    if (ovh_q && !ovh_clk)
      falls++;
    if (!sys_rst && hdlc_byte.valid) begin
      check("demand_clk", 8'(dem_clk), 8'h01);
      check("ovh_parked", 8'(ovh_clk), 8'h00);
      if (bytes > 0) begin
        check("hdlc_byte", hdlc_byte.data, {hi, ser_in, ins_en, lo});
        check("byte_period", 8'((cyc - last_byte) inside {[98:102]}), 8'h01);
      end
      last_byte = cyc;
      bytes++;
    end
    ovh_q = ovh_clk;
  end

  task automatic wait_falls(input int n);
    int target;
    target = falls + n;
    while (falls < target)
      @(negedge clk);
  endtask

  // every slot taken while enabled
  task automatic scen_insert_on();
    int v0;
    en_req = 1'b1;
    wait_falls(2);
    v0 = valids;
    wait_falls(6);
    check("count_on", 8'(valids - v0), 8'h06);
  endtask

  // nothing taken while disabled, clock and marker still run
  task automatic scen_insert_off();
    int v0;
    int r0;
    en_req = 1'b0;
    wait_falls(2);
    v0 = valids;
    r0 = rises;
    wait_falls(6);
    check("count_off", 8'(valids - v0), 8'h00);
    check("rises_off", 8'(rises - r0), 8'h06);
    check("dem_idle", 8'(dem_clk), 8'h00);
  endtask

  // hdlc mode parks the overhead port and takes bytes
  task automatic scen_hdlc();
    int r0;
    check("no_early_bytes", 8'(bytes), 8'h00);
    en_req = 1'b1;
    wait_falls(1);
    hdlc_mode = 1'b1;
    r0 = rises;
    while (bytes < 6)
      @(negedge clk);
    check("rises_hdlc", 8'(rises - r0), 8'h00);
    check("mark_parked", 8'(mark), 8'h00);
  endtask

  initial begin
    sys_rst = 1'b1;
    hdlc_mode = 1'b0;
    en_req = 1'b0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    scen_insert_on();
    scen_insert_off();
    scen_hdlc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
